// ==== rtl/sps_sram_if.sv ====
/*
  Pin-level logic of a split-port burst SRAM: separate read and write ports
  sharing one multiplexed address bus, two-word bursts on both input-clock
  edges, echo clocks and a data-valid flag.
  Assumes the core clock runs several times faster than the input clock
  pair, with at least three core cycles per half period of the pair.
*/
`timescale 1ns/10ps
`default_nettype none
module sps_sram_if
  import sps_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 21,
  parameter int LANES  = DATA_W / LANE_W
)
(
  input  wire logic              clk,                       // Core clock
  input  wire logic              reset_n,                   // Async reset
  input  wire logic              posClk,                    // Positive input clock pin
  input  wire logic              negClk,                    // Negative input clock pin
  input  wire logic              write_port_select_n,       // Write port select
  input  wire logic              read_port_select_n,        // Read port select
  input  wire logic [LANES-1:0]  byte_lane_write_select_n,  // Lane write selects
  input  wire logic [ADDR_W-1:0] addrIn,                    // Shared address bus
  input  wire logic [DATA_W-1:0] writeDataIn,               // Write data bus
  input  wire logic              loop_bypass_n,             // Low picks one-cycle latency
  input  wire logic              input_termination_select,  // Termination range strap
  output logic      [DATA_W-1:0] readDataOut,               // Read data bus
  output logic                   readDataOe_n,              // Low while read data driven
  output logic                   read_data_valid_flag,      // Read data valid
  output logic                   echo_clock_out,            // Echo clock
  output logic                   echo_clock_out_n,          // Complementary echo clock
  output logic                   termHighRange              // Termination on data, lanes, clocks
);
  localparam int SYNC_W = 4 + LANES + ADDR_W + DATA_W + 2;
  localparam int WORD_W = 2 * DATA_W;
  // Idle pin levels, so the edge detectors see no false edge when reset lets go
  localparam logic [SYNC_W-1:0] SYNC_RST = {4'h7, {LANES{1'b1}}, {(ADDR_W + DATA_W){1'b0}}, 2'h3};

  function automatic logic [WORD_W-1:0] merge_lanes(input logic [WORD_W-1:0] oldW,
                                                    input logic [WORD_W-1:0] newW,
                                                    input logic [2*LANES-1:0] be);
    logic [WORD_W-1:0] res;
    res = oldW;
    for (int i = 0; i < 2*LANES; i++)
    begin
      if (be[i])
      begin
        res[i*LANE_W +: LANE_W] = newW[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : merge_lanes

  logic [SYNC_W-1:0] syncA_ff;
  logic [SYNC_W-1:0] syncB_ff;
  logic              posPrev_ff;
  logic              negPrev_ff;

  // Every pin, clocks included, crosses through the same depth so beats stay aligned
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_ff   <= SYNC_RST;
      syncB_ff   <= SYNC_RST;
      posPrev_ff <= 1'b0;
      negPrev_ff <= 1'b1;
    end
    else
    begin
      syncA_ff   <= {posClk, negClk, write_port_select_n, read_port_select_n, byte_lane_write_select_n,
                     addrIn, writeDataIn, loop_bypass_n, input_termination_select};
      syncB_ff   <= syncA_ff;
      posPrev_ff <= syncB_ff[SYNC_W-1];
      negPrev_ff <= syncB_ff[SYNC_W-2];
    end
  end

  logic              posS;
  logic              negS;
  logic              wrSelN;
  logic              rdSelN;
  logic [LANES-1:0]  laneN;
  logic [ADDR_W-1:0] addrS;
  logic [DATA_W-1:0] dinS;
  logic              bypassN;
  logic              termSel;
  logic              posRise;
  logic              negRise;

  assign {posS, negS, wrSelN, rdSelN, laneN, addrS, dinS, bypassN, termSel} = syncB_ff;
  assign posRise = posS & ~posPrev_ff;
  assign negRise = negS & ~negPrev_ff;

  sps_wr_state_t     wrState_ff;
  logic [DATA_W-1:0] wrWord0_ff;
  logic [LANES-1:0]  wrMask0N_ff;
  logic              memWrEn_ff;
  logic [ADDR_W-1:0] memWrAddr_ff;
  logic [WORD_W-1:0] memWrData_ff;
  logic [2*LANES-1:0] memWrBe_ff;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrState_ff   <= SPS_WR_IDLE;
      wrWord0_ff   <= '0;
      wrMask0N_ff  <= '1;
      memWrEn_ff   <= 1'b0;
      memWrAddr_ff <= '0;
      memWrData_ff <= '0;
      memWrBe_ff   <= '0;
    end
    else
    begin
      memWrEn_ff <= 1'b0;
      case (wrState_ff)
        SPS_WR_IDLE:
        begin
          if (posRise && !wrSelN)
          begin
            wrWord0_ff  <= dinS;
            wrMask0N_ff <= laneN;
            wrState_ff  <= SPS_WR_BEAT1;
          end
        end
        SPS_WR_BEAT1:
        begin
          if (negRise)
          begin
            memWrEn_ff   <= 1'b1;
            memWrAddr_ff <= addrS;
            memWrData_ff <= {dinS, wrWord0_ff};
            memWrBe_ff   <= {~laneN, ~wrMask0N_ff};
            wrState_ff   <= SPS_WR_IDLE;
          end
        end
        default:
        begin
          wrState_ff <= SPS_WR_IDLE;
        end
      endcase
    end
  end

  logic              memRdEn_ff;
  logic              rdLoad_ff;
  logic [ADDR_W-1:0] rdAddr_ff;
  logic [WORD_W-1:0] memRdData;
  logic [2:0]        stValid_ff;
  logic [WORD_W-1:0] st0Data_ff;
  logic [WORD_W-1:0] st1Data_ff;
  logic [WORD_W-1:0] st2Data_ff;
  logic              fwdHit;

  // Write commits one core cycle after its negative edge, so a read in the same cycle
  // has already fetched the old data and must be patched here
  assign fwdHit = negRise && (wrState_ff == SPS_WR_BEAT1) && stValid_ff[0] && (addrS == rdAddr_ff);

  sps_burst_mem
  #(
    .ADDR_W (ADDR_W),
    .WORD_W (WORD_W),
    .BE_W   (2*LANES)
  )
  u_mem
  (
    .clk    (clk),
    .wrEn   (memWrEn_ff),
    .wrAddr (memWrAddr_ff),
    .wrData (memWrData_ff),
    .wrBe   (memWrBe_ff),
    .rdEn   (memRdEn_ff),
    .rdAddr (rdAddr_ff),
    .rdData (memRdData)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memRdEn_ff <= 1'b0;
      rdLoad_ff  <= 1'b0;
      rdAddr_ff  <= '0;
      stValid_ff <= '0;
      st0Data_ff <= '0;
      st1Data_ff <= '0;
      st2Data_ff <= '0;
    end
    else
    begin
      memRdEn_ff <= posRise && !rdSelN;
      rdLoad_ff  <= memRdEn_ff;
      if (posRise)
      begin
        stValid_ff <= {stValid_ff[1:0], !rdSelN};
        st1Data_ff <= st0Data_ff;
        st2Data_ff <= st1Data_ff;
        if (!rdSelN)
        begin
          rdAddr_ff <= addrS;
        end
      end
      if (rdLoad_ff)
      begin
        st0Data_ff <= memRdData;
      end
      else if (fwdHit)
      begin
        st0Data_ff <= merge_lanes(st0Data_ff, {dinS, wrWord0_ff}, {~laneN, ~wrMask0N_ff});
      end
    end
  end

  logic              drive;
  logic [DATA_W-1:0] driveWord;
  logic [DATA_W-1:0] rdOut_ff;
  logic              rdOeN_ff;
  logic              rdValid_ff;

  always_comb
  begin
    drive     = 1'b0;
    driveWord = '0;
    if (bypassN)
    begin
      if (negRise)
      begin
        drive     = stValid_ff[2];
        driveWord = st2Data_ff[DATA_W-1:0];
      end
      else if (posRise)
      begin
        drive     = stValid_ff[2];
        driveWord = st2Data_ff[WORD_W-1:DATA_W];
      end
    end
    else
    begin
      if (posRise)
      begin
        drive     = stValid_ff[0];
        driveWord = st0Data_ff[DATA_W-1:0];
      end
      else if (negRise)
      begin
        drive     = stValid_ff[1];
        driveWord = st1Data_ff[WORD_W-1:DATA_W];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdOut_ff   <= '0;
      rdOeN_ff   <= OE_N_RST;
      rdValid_ff <= 1'b0;
    end
    else if (posRise || negRise)
    begin
      rdValid_ff <= drive;
      rdOeN_ff   <= ~drive;
      if (drive)
      begin
        rdOut_ff <= driveWord;
      end
    end
  end

  logic echo_ff;
  logic echoN_ff;

  // Echo follows the same synchronised clock as the valid flag, keeping them edge aligned
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      echo_ff  <= 1'b0;
      echoN_ff <= 1'b1;
    end
    else
    begin
      echo_ff  <= posS;
      echoN_ff <= ~posS;
    end
  end

  logic [1:0] termCnt_ff;
  logic       termHigh_ff;

  // A floating strap cannot be seen here; the pad pull-up must make it read high
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      termCnt_ff  <= '0;
      termHigh_ff <= TERM_RST;
    end
    else if (termCnt_ff != TERM_CNT_MAX)
    begin
      termCnt_ff <= termCnt_ff + 2'h1;
      if (termCnt_ff == TERM_CNT_MAX - 2'h1)
      begin
        termHigh_ff <= termSel;
      end
    end
  end

  assign readDataOut          = rdOut_ff;
  assign readDataOe_n         = rdOeN_ff;
  assign read_data_valid_flag = rdValid_ff;
  assign echo_clock_out       = echo_ff;
  assign echo_clock_out_n     = echoN_ff;
  assign termHighRange        = termHigh_ff;

  property p_wr_commit;
    @(posedge clk) disable iff (!reset_n)
      (negRise && wrState_ff == SPS_WR_BEAT1) |=> (memWrEn_ff && memWrAddr_ff == $past(addrS));
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("write not committed after second beat");

  property p_wr_start;
    @(posedge clk) disable iff (!reset_n)
      (wrState_ff == SPS_WR_IDLE) ##1 (wrState_ff == SPS_WR_BEAT1) |-> $past(posRise && !wrSelN);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write started without positive edge select");

  property p_rd_ignored;
    @(posedge clk) disable iff (!reset_n)
      (posRise && rdSelN) |=> !stValid_ff[0];
  endproperty
  a_rd_ignored: assert property (p_rd_ignored) else $error("deselected read was accepted");

  property p_valid_oe;
    @(posedge clk) disable iff (!reset_n)
      rdValid_ff == !rdOeN_ff;
  endproperty
  a_valid_oe: assert property (p_valid_oe) else $error("valid flag and drive disagree");

  property p_release;
    @(posedge clk) disable iff (!reset_n)
      ((posRise || negRise) && !drive) |=> (rdOeN_ff ##1 rdOeN_ff);
  endproperty
  a_release: assert property (p_release) else $error("read data not released");

  property p_latency;
    @(posedge clk) disable iff (!reset_n)
      ($rose(rdValid_ff) && $past(bypassN)) |-> $past(negRise);
  endproperty
  a_latency: assert property (p_latency) else $error("burst began on wrong edge in normal mode");

  property p_echo;
    @(posedge clk) disable iff (!reset_n)
      (echo_ff != echoN_ff) and ($rose(echo_ff) |-> $past(posRise));
  endproperty
  a_echo: assert property (p_echo) else $error("echo clocks not complementary");

  property p_term;
    @(posedge clk) disable iff (!reset_n)
      (termCnt_ff == TERM_CNT_MAX) |=> $stable(termHigh_ff);
  endproperty
  a_term: assert property (p_term) else $error("termination range changed after power-up");

  property p_rd_fetch;
    @(posedge clk) disable iff (!reset_n)
      (posRise && !rdSelN) |-> ##2 rdLoad_ff;
  endproperty
  a_rd_fetch: assert property (p_rd_fetch) else $error("read fetch not loaded in time");
endmodule : sps_sram_if
`default_nettype wire

// ==== rtl/sps_pkg.sv ====
/*
  Shared constants for the split-port burst SRAM pin interface.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sps_pkg;
  localparam int LANE_W    = 9;     // Bits gated by one lane select
  localparam int SYNC_LEN  = 2;     // Flip-flops in each pin synchroniser
  localparam int TERM_WAIT = 3;     // Cycles after reset before the strap is caught
  localparam logic [1:0] TERM_CNT_MAX = 2'h3;
  localparam logic TERM_RST  = 1'b1;  // High range until the strap is caught
  localparam logic OE_N_RST  = 1'b1;  // Read data released after reset
  localparam logic [1:0] WR_IDLE  = 2'h0;
  localparam logic [1:0] WR_BEAT1 = 2'h1;

  typedef enum logic [1:0]
  {
    SPS_WR_IDLE  = WR_IDLE,
    SPS_WR_BEAT1 = WR_BEAT1
  } sps_wr_state_t;
endpackage : sps_pkg

// ==== rtl/sps_burst_mem.sv ====
/*
  Burst memory: each location holds the two words of one burst, so the two
  halves behave as the two internal arrays. One write port with lane
  enables, one read port with registered read data.
  Assumes write and read requests come from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module sps_burst_mem
  import sps_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int WORD_W = 36,
  parameter int BE_W   = 4
)
(
  input  wire logic              clk,     // Core clock
  input  wire logic              wrEn,    // Write strobe
  input  wire logic [ADDR_W-1:0] wrAddr,  // Write location
  input  wire logic [WORD_W-1:0] wrData,  // Both burst words
  input  wire logic [BE_W-1:0]   wrBe,    // Lane enables, active high
  input  wire logic              rdEn,    // Read strobe
  input  wire logic [ADDR_W-1:0] rdAddr,  // Read location
  output logic      [WORD_W-1:0] rdData   // Registered read data
);
  logic [WORD_W-1:0] memArray [0:(2**ADDR_W)-1];
  logic [WORD_W-1:0] rdData_ff;

  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      for (int i = 0; i < BE_W; i++)
      begin
        if (wrBe[i])
        begin
          memArray[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rdEn)
    begin
      rdData_ff <= memArray[rdAddr];
    end
  end

  assign rdData = rdData_ff;
endmodule : sps_burst_mem
`default_nettype wire

// ==== testbench/sps_host_model.sv ====
/*
  Host controller model: drives the input clock pair, both port selects,
  lane selects, the shared address and write data.
  Assumes a core clock with six cycles per half period of the pair.
*/
`timescale 1ns/10ps
`default_nettype none
module sps_host_model
  import sps_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 6,
  parameter int LANES  = 2
)
(
  input  wire logic              clk,       // Core clock
  output var  logic              posClk,    // Positive input clock
  output var  logic              negClk,    // Negative input clock
  output var  logic              wrSel_n,   // Write port select
  output var  logic              rdSel_n,   // Read port select
  output var  logic [LANES-1:0]  laneSel_n, // Lane write selects
  output var  logic [ADDR_W-1:0] addr,      // Shared address
  output var  logic [DATA_W-1:0] wrData     // Write data
);
  int kCount = 0;
  int kPhase = 1;

  initial
  begin
    posClk = 1'b0;
    negClk = 1'b1;
    wrSel_n = 1'b1;
    rdSel_n = 1'b1;
    laneSel_n = '1;
    addr = '0;
    wrData = '0;
  end

  // Pins settle two cycles before the clock edge so the synchroniser never races them
  task automatic half(input logic p, r, w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [LANES-1:0] b);
    #1;
    rdSel_n = r;
    wrSel_n = w;
    addr = {a[0], a[ADDR_W-1:1]};
    wrData = d;
    laneSel_n = b;
    repeat (2) @(posedge clk);
    #1;
    posClk = p;
    negClk = !p;
    kPhase = p ? 0 : 1;
    if (p)
      kCount++;
    repeat (4) @(posedge clk);
  endtask : half

  task automatic kCycle(input logic rN, wN, input logic [ADDR_W-1:0] rA, wA,
                        input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] b0, b1);
    half(1'b1, rN, wN, rA, d0, b0);
    half(1'b0, rN, wN, wA, d1, b1);
  endtask : kCycle
endmodule : sps_host_model
`default_nettype wire

// ==== testbench/split_port_burst_sram_if_test.sv ====
/*
  Self-checking bench for the split-port SRAM pin logic: scenario tasks,
  a reference memory and a monitor that collects read words on echo edges.
  Assumes the host model above and the narrow variant with a small address.
*/
`timescale 1ns/10ps
`default_nettype none
module split_port_burst_sram_if_test;
  import sps_pkg::*;
  localparam int DW = 18;
  localparam int AW = 6;
  localparam int LN = 2;
  logic          clk;
  logic          reset_n;
  logic          bypass_n = 1'b1;
  logic          strap = 1'b0;
  logic          posClk, negClk, wrSel_n, rdSel_n;
  logic [LN-1:0] laneSel_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] wrData, rdData;
  logic          oe_n, valid, echo, echo_n, termHi;
  logic          echoPrev = 1'b0;
  logic [2*DW-1:0] mdl [0:63];
  logic [DW-1:0] gotQ[$], expQ[$];
  int            gotP[$], expP[$];
  int            error_cnt = 0;
  int            cmp_count = 0;
  int            toggles = 0;

  sps_host_model #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) sps_host_model_i
  (
    .clk(clk), .posClk(posClk), .negClk(negClk), .wrSel_n(wrSel_n), .rdSel_n(rdSel_n),
    .laneSel_n(laneSel_n), .addr(addr), .wrData(wrData)
  );
  sps_sram_if #(.DATA_W(DW), .ADDR_W(AW)) sps_sram_if_i
  (
    .clk(clk), .reset_n(reset_n), .posClk(posClk), .negClk(negClk),
    .write_port_select_n(wrSel_n), .read_port_select_n(rdSel_n),
    .byte_lane_write_select_n(laneSel_n), .addrIn(addr), .writeDataIn(wrData),
    .loop_bypass_n(bypass_n), .input_termination_select(strap), .readDataOut(rdData),
    .readDataOe_n(oe_n), .read_data_valid_flag(valid), .echo_clock_out(echo),
    .echo_clock_out_n(echo_n), .termHighRange(termHi)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chkV(input logic [DW-1:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: exp %0h got %0h", $time, e, g);
    end
  endtask : chkV

  task automatic chkB(input logic e, g);
    chkV({17'h0, e}, {17'h0, g});
  endtask : chkB

  task automatic chkI(input int e, g);
    cmp_count++;
    if (g != e)
    begin
      error_cnt++;
      $display("mismatch at %0t: exp %0h got %0h", $time, e, g);
    end
  endtask : chkI

  function automatic logic [2*DW-1:0] merge(input logic [2*DW-1:0] old, nw, input logic [2*LN-1:0] be);
    merge = old;
    for (int i = 0; i < 2*LN; i++)
      if (!be[i])
        merge[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
  endfunction : merge

  // Latency is booked as half-cycle position: twice the cycle, plus one in the negative half
  task automatic cyc(input logic rN, wN, input logic [AW-1:0] rA, wA, input logic [DW-1:0] d0, d1,
                     input logic [LN-1:0] b0, b1);
    int c;
    sps_host_model_i.kCycle(rN, wN, rA, wA, d0, d1, b0, b1);
    c = sps_host_model_i.kCount;
    if (!wN)
      mdl[wA] = merge(mdl[wA], {d1, d0}, {b1, b0});
    if (!rN)
    begin
      expQ.push_back(mdl[rA][DW-1:0]);
      expQ.push_back(mdl[rA][2*DW-1:DW]);
      expP.push_back(bypass_n ? 2*c+5 : 2*c+2);
      expP.push_back(bypass_n ? 2*c+6 : 2*c+3);
    end
  endtask : cyc

  // Deselected phases carry a changing pattern, never the last value
  task automatic idle(input int n);
    repeat (n) cyc(1'b1, 1'b1, ~addr, addr, ~wrData, wrData, ~laneSel_n, laneSel_n);
  endtask : idle

  task automatic drain(input string name);
    idle(4);
    chkI(expQ.size(), gotQ.size());
    while (expQ.size() > 0 && gotQ.size() > 0)
    begin
      chkV(expQ.pop_front(), gotQ.pop_front());
      chkI(expP.pop_front(), gotP.pop_front());
    end
    chkB(1'b1, oe_n);
    chkB(1'b0, valid);
    expQ.delete();
    gotQ.delete();
    expP.delete();
    gotP.delete();
    $display("test %s done", name);
  endtask : drain

  always @(posedge clk)
  begin
    echoPrev <= echo;
    if (reset_n === 1'b1 && echo !== echoPrev)
    begin
      toggles++;
      chkB(~echo, echo_n);
      chkB(~oe_n, valid);
      if (valid === 1'b1)
      begin
        gotQ.push_back(rdData);
        gotP.push_back(2*sps_host_model_i.kCount + sps_host_model_i.kPhase);
      end
    end
  end

  task automatic test_write_read();
    cyc(1'b1, 1'b0, 6'h3F, 6'h05, 18'h1ABCD, 18'h2F00F, 2'h0, 2'h0);
    cyc(1'b1, 1'b0, 6'h05, 6'h06, 18'h00F0F, 18'h3C3C3, 2'h0, 2'h0);
    cyc(1'b0, 1'b1, 6'h05, 6'h3A, 18'h3FFFF, 18'h00000, 2'h0, 2'h0);
    cyc(1'b0, 1'b1, 6'h06, 6'h05, 18'h3FFFF, 18'h00000, 2'h0, 2'h0);
    drain("write_read");
  endtask : test_write_read

  task automatic test_lanes();
    cyc(1'b1, 1'b0, 6'h00, 6'h09, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
    cyc(1'b1, 1'b0, 6'h00, 6'h09, 18'h00000, 18'h00000, 2'h2, 2'h1);
    cyc(1'b0, 1'b1, 6'h09, 6'h00, 18'h00000, 18'h00000, 2'h3, 2'h3);
    drain("lanes");
  endtask : test_lanes

  task automatic test_deselect();
    cyc(1'b1, 1'b1, 6'h05, 6'h05, 18'h00000, 18'h00000, 2'h0, 2'h0);
    cyc(1'b0, 1'b1, 6'h05, 6'h05, 18'h00000, 18'h00000, 2'h0, 2'h0);
    drain("deselect");
  endtask : test_deselect

  task automatic test_forward();
    cyc(1'b0, 1'b0, 6'h0C, 6'h0C, 18'h12345, 18'h2ABCD, 2'h0, 2'h0);
    cyc(1'b0, 1'b0, 6'h0C, 6'h0D, 18'h11111, 18'h22222, 2'h0, 2'h0);
    drain("forward");
  endtask : test_forward

  task automatic test_bypass();
    bypass_n <= 1'b0;
    cyc(1'b1, 1'b0, 6'h00, 6'h11, 18'h0A5A5, 18'h35A5A, 2'h0, 2'h0);
    cyc(1'b0, 1'b1, 6'h11, 6'h00, 18'h00000, 18'h00000, 2'h0, 2'h0);
    cyc(1'b0, 1'b0, 6'h0D, 6'h12, 18'h01234, 18'h04321, 2'h0, 2'h0);
    drain("bypass");
    bypass_n <= 1'b1;
  endtask : test_bypass

  task automatic test_echo();
    int t0;
    @(negedge clk);
    t0 = toggles;
    @(posedge clk);
    idle(4);
    @(negedge clk);
    chkI(8, toggles - t0);
    $display("test echo done");
  endtask : test_echo

  // Mid-run reset with the strap high: range returns high and is caught only once
  task automatic test_reset();
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    chkB(1'b1, termHi);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge clk);
    chkB(1'b1, termHi);
    strap <= 1'b0;
    cyc(1'b0, 1'b1, 6'h0D, 6'h00, 18'h00000, 18'h00000, 2'h0, 2'h0);
    drain("reset");
    chkB(1'b1, termHi);
  endtask : test_reset

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // About ten times the expected run
  initial
  begin
    #50000;
    error_cnt++;
    test_done();
  end

  initial
  begin
    reset_n = 1'b0;
    repeat (12) @(posedge clk);
    chkB(1'b1, oe_n);
    chkB(1'b0, valid);
    chkB(1'b1, echo_n);
    chkB(1'b1, termHi);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge clk);
    chkB(1'b0, termHi);
    strap <= 1'b1;
    test_write_read();
    test_lanes();
    test_deselect();
    test_forward();
    test_bypass();
    test_echo();
    chkB(1'b0, termHi);
    test_reset();
    test_done();
  end
endmodule : split_port_burst_sram_if_test
`default_nettype wire
